// ### dv/acdpc_assertions.sv
// Concurrent checks on the ports of the clock and pin control block.
`timescale 1ns/1ps
module acdpc_assertions (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [1:0]  chan_power_down,
	input wire logic [1:0]  chan_standby,
	input wire logic [1:0]  temp_diode_route,
	input wire logic        fd_a_oe,
	input wire logic        fd_b_oe,
	input wire logic [15:0] fine_skew,
	input wire logic        fine_delay_active,
	input wire logic        datapath_reset
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_reset_quiet: assert property ($past(srst) |-> !fd_a_oe && !fd_b_oe && !datapath_reset)
		else $error("pins or datapath reset active right after reset");
	a_dp_single: assert property (datapath_reset |=> !datapath_reset)
		else $error("datapath reset longer than one cycle");
	a_dp_cause: assert property ($rose(datapath_reset) |-> ##[0:1] fine_delay_active)
		else $error("datapath reset without fine delay enable");
	a_fine_gated: assert property (!fine_delay_active |-> fine_skew == 16'h0000)
		else $error("fine skew applied while disabled");
	a_fine_sat: assert property (fine_delay_active |->
		$signed(fine_skew[7:0]) >= -88 && $signed(fine_skew[15:8]) >= -88)
		else $error("fine skew below saturation floor");
	a_status_read: assert property (reg_rd && reg_addr == 12'h11c |=> reg_rdata[7:1] == 7'h00)
		else $error("clock status reserved bits set");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h000 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_diode_quiet: assert property (temp_diode_route != 2'b00 |-> !fd_a_oe)
		else $error("first pin driven while diode routed");
	a_sleep_excl: assert property ((chan_power_down & chan_standby) == 2'b00)
		else $error("channel both powered down and in standby");
endmodule : acdpc_assertions

bind acdpc_top acdpc_assertions u_chk (.*);

// ### dv/acdpc_host.sv
// Host model that drives the register port of the block.
`timescale 1ns/1ps
module acdpc_host (
	input  wire logic        core_clk,
	output logic      [11:0] reg_addr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [1:0]  chan_select,
	input  wire logic [7:0]  reg_rdata
);
	initial begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chan_select = 2'b01;
	end
	// Released address and data are inverted so stale values cannot pass.
	task automatic wr(input logic [1:0] ch, input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk);
		chan_select = ch;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [1:0] ch, input logic [11:0] a, output logic [7:0] d);
		@(negedge core_clk);
		chan_select = ch;
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
endmodule : acdpc_host

// ### dv/testbench.sv
// Self-checking bench for the clock and pin control block.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	logic core_clk = 1'b0, srst = 1'b1, sleep_control_pin = 1'b0, clock_detect_in = 1'b1;
	logic sysref_in = 1'b0, lmfc_pulse = 1'b1, sync_internal_n = 1'b0;
	logic [1:0] fast_thresh_flag = 2'b01;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, fd_a_out, fd_a_oe, fd_b_out, fd_b_oe, div_clk_en;
	logic fine_delay_active, datapath_reset;
	logic [1:0] chan_select, chan_power_down, chan_standby, temp_diode_route;
	logic [1:0] sample_clk_en, sample_half_cycle;
	logic [15:0] fine_skew;
	int fails = 0, total_checks = 0, cyc = 0, dp_cnt = 0;
	acdpc_top u_dut (.*);
	acdpc_host u_host (.*);
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (datapath_reset === 1'b1) dp_cnt++;
		cyc++;
		if (cyc == 6000) begin
			fails++;
			give_verdict();
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		logic [11:0] ad[11] = '{12'h028, 12'h03f, 12'h040, 12'h10b, 12'h10c, 12'h10d,
			12'h117, 12'h118, 12'h11c, 12'h000, 12'h11c};
		logic [7:0] ex[11] = '{8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 11; i++) begin
			if (i == 10) clock_detect_in = 1'b0;
			if (i == 10) repeat (6) @(negedge core_clk);
			u_host.rd(2'b01, ad[i], d);
			`CHK(d, ex[i])
		end
		u_host.wr(2'b01, 12'h028, 8'hff);
		u_host.rd(2'b01, 12'h028, d);
		`CHK(d, 8'h01)
		u_host.wr(2'b01, 12'h10d, 8'hff);
		u_host.rd(2'b01, 12'h10d, d);
		`CHK(d, 8'h8f)
	endtask : t_regs
	task automatic t_fine;
		u_host.wr(2'b01, 12'h118, 8'h05);
		u_host.wr(2'b10, 12'h118, 8'h80);
		u_host.rd(2'b10, 12'h118, d);
		`CHK(d, 8'h80)
		repeat (3) @(negedge core_clk);
		`CHK(fine_skew, 16'h0000)
		u_host.wr(2'b01, 12'h117, 8'h01);
		repeat (3) @(negedge core_clk);
		`CHK(fine_skew, 16'ha805)
		`CHK(dp_cnt, 1)
		u_host.wr(2'b01, 12'h117, 8'h00);
		repeat (3) @(negedge core_clk);
		`CHK(fine_skew, 16'h0000)
	endtask : t_fine
	task automatic t_div;
		logic [2:0] code[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
		int n;
		int m;
		u_host.wr(2'b01, 12'h10c, 8'h03);
		for (int i = 0; i < 4; i++) begin
			u_host.wr(2'b01, 12'h10b, {5'h00, code[i]});
			repeat (4) @(negedge core_clk);
			n = 0;
			m = 0;
			repeat (16) begin
				@(negedge core_clk);
				if (div_clk_en === 1'b1) n++;
				if (sample_clk_en[0] === 1'b1) m++;
			end
			`CHK(n, 16 >> i)
			`CHK(m, 16 >> i)
		end
		`CHK(sample_half_cycle, 2'b01)
	endtask : t_div
	// Reference edge lands a set number of cycles after a divided tick; the
	// distance to the next tick shows whether the divider was realigned.
	task automatic t_auto;
		logic [7:0] cfg[5] = '{8'h8f, 8'h8f, 8'h8f, 8'h80, 8'h0f};
		int ofs[5] = '{2, 0, 4, 0, 2};
		int ex[5] = '{10, 8, 4, 10, 6};
		int n;
		u_host.wr(2'b01, 12'h10b, 8'h07);
		for (int i = 0; i < 5; i++) begin
			u_host.wr(2'b01, 12'h10d, cfg[i]);
			n = 0;
			while (div_clk_en !== 1'b1 && n < 16) begin
				@(negedge core_clk);
				n++;
			end
			repeat (ofs[i]) @(negedge core_clk);
			sysref_in = 1'b1;
			n = 0;
			do begin
				@(negedge core_clk);
				n++;
			end while (div_clk_en !== 1'b1 && n < 20);
			sysref_in = 1'b0;
			`CHK(n, ex[i])
			repeat (4) @(negedge core_clk);
		end
	endtask : t_auto
	task automatic t_sleep;
		logic [1:0] md[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
		logic [3:0] ex[5] = '{4'b1100, 4'b0011, 4'b0000, 4'b0000, 4'b1000};
		sleep_control_pin = 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (i == 4) u_host.wr(2'b01, 12'h03f, 8'h80);
			u_host.wr(2'b01, 12'h040, {md[i], 6'h3f});
			repeat (6) @(negedge core_clk);
			`CHK({chan_power_down, chan_standby}, ex[i])
		end
		sleep_control_pin = 1'b0;
		repeat (6) @(negedge core_clk);
		`CHK({chan_power_down, chan_standby}, 4'b0000)
	endtask : t_sleep
	task automatic t_pins;
		logic [7:0] cfg[4] = '{8'h88, 8'h81, 8'h96, 8'hbb};
		logic [5:0] ex[4] = '{6'b111100, 6'b111000, 6'b101000, 6'b000011};
		u_host.wr(2'b11, 12'h028, 8'h01);
		for (int i = 0; i < 4; i++) begin
			u_host.wr(2'b01, 12'h040, cfg[i]);
			repeat (4) @(negedge core_clk);
			`CHK({fd_a_oe, fd_a_out, fd_b_oe, fd_b_out, temp_diode_route}, ex[i])
		end
	endtask : t_pins
	// ****************************************
	// Verdict
	// ****************************************
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (5) @(negedge core_clk);
		srst = 1'b0;
		t_regs();
		t_fine();
		t_div();
		t_auto();
		t_sleep();
		t_pins();
		give_verdict();
	end
endmodule : testbench

// ### logic/acdpc_pkg.sv
// Package with register offsets, field positions, reset values and codes for the clock/pin block.
package acdpc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] ADDR_TEMP_DIODE_SELECT   = 12'h028;
	localparam logic [11:0] ADDR_SLEEP_PIN_ENABLE    = 12'h03f;
	localparam logic [11:0] ADDR_PIN_FUNCTION_SELECT = 12'h040;
	localparam logic [11:0] ADDR_INPUT_CLOCK_DIVIDE  = 12'h10b;
	localparam logic [11:0] ADDR_DIVIDED_CLOCK_PHASE = 12'h10c;
	localparam logic [11:0] ADDR_AUTO_PHASE_SKEW     = 12'h10d;
	localparam logic [11:0] ADDR_FINE_DELAY_ENABLE   = 12'h117;
	localparam logic [11:0] ADDR_SAMPLE_CLOCK_SKEW   = 12'h118;
	localparam logic [11:0] ADDR_INPUT_CLOCK_PRESENT = 12'h11c;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_TEMP_DIODE_SELECT   = 8'h00;
	localparam logic [7:0] RST_SLEEP_PIN_ENABLE    = 8'h00;
	localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h3f;
	localparam logic [7:0] RST_INPUT_CLOCK_DIVIDE  = 8'h00;
	localparam logic [7:0] RST_DIVIDED_CLOCK_PHASE = 8'h00;
	localparam logic [7:0] RST_AUTO_PHASE_SKEW     = 8'h00;
	localparam logic [7:0] RST_FINE_DELAY_ENABLE   = 8'h00;
	localparam logic [7:0] RST_SAMPLE_CLOCK_SKEW   = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DIODE_BIT      = 0;
	localparam int SLEEP_IGN_BIT  = 7;
	localparam int SLEEP_MODE_HI  = 7;
	localparam int SLEEP_MODE_LO  = 6;
	localparam int FDB_HI         = 5;
	localparam int FDB_LO         = 3;
	localparam int FDA_HI         = 2;
	localparam int FDA_LO         = 0;
	localparam int DIV_HI         = 2;
	localparam int DIV_LO         = 0;
	localparam int PHASE_HI       = 3;
	localparam int PHASE_LO       = 0;
	localparam int AUTO_BIT       = 7;
	localparam int NEG_WIN_HI     = 3;
	localparam int NEG_WIN_LO     = 2;
	localparam int POS_WIN_HI     = 1;
	localparam int POS_WIN_LO     = 0;
	localparam int FINE_EN_BIT    = 0;

	// ****************************************
	// Codes
	// ****************************************
	localparam logic [1:0] SLEEP_POWER_DOWN = 2'h0;
	localparam logic [1:0] SLEEP_STANDBY    = 2'h1;
	localparam logic [2:0] FD_FAST_FLAG     = 3'h0;
	localparam logic [2:0] FD_LMFC          = 3'h1;
	localparam logic [2:0] FD_TEMP_DIODE    = 3'h3;
	localparam logic [2:0] FD_DISABLE       = 3'h7;
	localparam logic [2:0] DIV_BY_1         = 3'h0;
	localparam logic [2:0] DIV_BY_2         = 3'h1;
	localparam logic [2:0] DIV_BY_4         = 3'h3;
	localparam logic [2:0] DIV_BY_8         = 3'h7;
	localparam logic [7:0] FINE_SKEW_MIN    = 8'ha8;

endpackage : acdpc_pkg

// ### logic/acdpc_top.sv
// Clock divider, divider phase, fine delay, clock status and multipurpose pin control.
//
// Summary of operation
// - Per-channel bit routes temperature diode when one; needs pin function selection.
// - Per-channel top bit one makes channel ignore the sleep control pin.
// - Pin mode field: 00 power down, 01 standby, 10 pin disabled.
// - Second pin code: 000 fast flag, 001 LMFC, 111 off, else SYNC.
// - First pin: same choices, plus one code routing temperature diode.
// - Divider code 000/001/011/111 divides input clock by 1/2/4/8.
// - Per-channel phase delays divided clock by value times half cycle.
// - Top divider-control bit enables auto phase adjust; only when ratio above one.
// - Negative skew window tolerates zero to three device clocks.
// - Positive skew window tolerates zero to three device clocks.
// - Fine delay enable turns on fine adjust and triggers a datapath reset.
// - Fine delay is two's complement, saturating at -88 and below.
// - Fine delay value acts only while fine delay enable is set.
// - Read-only status bit shows one while an input clock is detected.
`timescale 1ns/1ps

module acdpc_top (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [1:0] chan_select,
	output logic      [7:0] reg_rdata,
	input  wire logic       sleep_control_pin,
	input  wire logic       clock_detect_in,
	input  wire logic       sysref_in,
	input  wire logic [1:0] fast_thresh_flag,
	input  wire logic       lmfc_pulse,
	input  wire logic       sync_internal_n,
	output logic [1:0]      chan_power_down,
	output logic [1:0]      chan_standby,
	output logic [1:0]      temp_diode_route,
	output logic            fd_a_out,
	output logic            fd_a_oe,
	output logic            fd_b_out,
	output logic            fd_b_oe,
	output logic            div_clk_en,
	output logic [1:0]      sample_clk_en,
	output logic [1:0]      sample_half_cycle,
	output logic [15:0]     fine_skew,
	output logic            fine_delay_active,
	output logic            datapath_reset
);

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0] diode_q   [2];
	logic [7:0] sleep_q   [2];
	logic [7:0] phase_q   [2];
	logic [7:0] skew_q    [2];
	logic [7:0] pinsel_q;
	logic [7:0] divider_q;
	logic [7:0] auto_q;
	logic [7:0] fine_en_q;

	wire wr_diode   = reg_wr && (reg_addr == acdpc_pkg::ADDR_TEMP_DIODE_SELECT);
	wire wr_sleep   = reg_wr && (reg_addr == acdpc_pkg::ADDR_SLEEP_PIN_ENABLE);
	wire wr_pinsel  = reg_wr && (reg_addr == acdpc_pkg::ADDR_PIN_FUNCTION_SELECT);
	wire wr_divider = reg_wr && (reg_addr == acdpc_pkg::ADDR_INPUT_CLOCK_DIVIDE);
	wire wr_phase   = reg_wr && (reg_addr == acdpc_pkg::ADDR_DIVIDED_CLOCK_PHASE);
	wire wr_auto    = reg_wr && (reg_addr == acdpc_pkg::ADDR_AUTO_PHASE_SKEW);
	wire wr_fine_en = reg_wr && (reg_addr == acdpc_pkg::ADDR_FINE_DELAY_ENABLE);
	wire wr_skew    = reg_wr && (reg_addr == acdpc_pkg::ADDR_SAMPLE_CLOCK_SKEW);

	// Only writable bits are stored, so reserved bits read back as zero.
	for (genvar c = 0; c < 2; c++) begin : g_chan_regs
		always_ff @(posedge core_clk) begin
			if (srst) begin
				diode_q[c] <= acdpc_pkg::RST_TEMP_DIODE_SELECT;
				sleep_q[c] <= acdpc_pkg::RST_SLEEP_PIN_ENABLE;
				phase_q[c] <= acdpc_pkg::RST_DIVIDED_CLOCK_PHASE;
				skew_q[c]  <= acdpc_pkg::RST_SAMPLE_CLOCK_SKEW;
			end else if (chan_select[c]) begin
				if (wr_diode)
					diode_q[c] <= {7'h00, reg_wdata[acdpc_pkg::DIODE_BIT]};
				if (wr_sleep)
					sleep_q[c] <= {reg_wdata[acdpc_pkg::SLEEP_IGN_BIT], 7'h00};
				if (wr_phase)
					phase_q[c] <= {4'h0, reg_wdata[acdpc_pkg::PHASE_HI:acdpc_pkg::PHASE_LO]};
				if (wr_skew)
					skew_q[c] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pinsel_q  <= acdpc_pkg::RST_PIN_FUNCTION_SELECT;
			divider_q <= acdpc_pkg::RST_INPUT_CLOCK_DIVIDE;
			auto_q    <= acdpc_pkg::RST_AUTO_PHASE_SKEW;
			fine_en_q <= acdpc_pkg::RST_FINE_DELAY_ENABLE;
		end else begin
			if (wr_pinsel)
				pinsel_q <= reg_wdata;
			if (wr_divider)
				divider_q <= {5'h00, reg_wdata[acdpc_pkg::DIV_HI:acdpc_pkg::DIV_LO]};
			if (wr_auto)
				auto_q <= reg_wdata & 8'h8f;
			if (wr_fine_en)
				fine_en_q <= {7'h00, reg_wdata[acdpc_pkg::FINE_EN_BIT]};
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {sysref_in, clock_detect_in, sleep_control_pin};
			sync2_q <= sync1_q;
		end
	end

	wire sleep_pin_s  = sync2_q[0];
	wire clk_present  = sync2_q[1];
	wire sysref_s     = sync2_q[2];

	// ****************************************
	// Register read-back
	// ****************************************
	// Per-channel registers read from channel A when it is selected, else from B.
	wire       rd_ch = ~chan_select[0];
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			acdpc_pkg::ADDR_TEMP_DIODE_SELECT:   rd_mux = diode_q[rd_ch];
			acdpc_pkg::ADDR_SLEEP_PIN_ENABLE:    rd_mux = sleep_q[rd_ch];
			acdpc_pkg::ADDR_PIN_FUNCTION_SELECT: rd_mux = pinsel_q;
			acdpc_pkg::ADDR_INPUT_CLOCK_DIVIDE:  rd_mux = divider_q;
			acdpc_pkg::ADDR_DIVIDED_CLOCK_PHASE: rd_mux = phase_q[rd_ch];
			acdpc_pkg::ADDR_AUTO_PHASE_SKEW:     rd_mux = auto_q;
			acdpc_pkg::ADDR_FINE_DELAY_ENABLE:   rd_mux = fine_en_q;
			acdpc_pkg::ADDR_SAMPLE_CLOCK_SKEW:   rd_mux = skew_q[rd_ch];
			acdpc_pkg::ADDR_INPUT_CLOCK_PRESENT: rd_mux = {7'h00, clk_present};
			default:                             rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// ****************************************
	// Clock divider and phase
	// ****************************************
	// Reserved divider codes fall back to divide by one.
	function automatic logic [2:0] div_mask(input logic [2:0] code);
		unique case (code)
			acdpc_pkg::DIV_BY_2: div_mask = 3'h1;
			acdpc_pkg::DIV_BY_4: div_mask = 3'h3;
			acdpc_pkg::DIV_BY_8: div_mask = 3'h7;
			default:             div_mask = 3'h0;
		endcase
	endfunction : div_mask

	wire [2:0] mask     = div_mask(divider_q[acdpc_pkg::DIV_HI:acdpc_pkg::DIV_LO]);
	wire [1:0] neg_win  = auto_q[acdpc_pkg::NEG_WIN_HI:acdpc_pkg::NEG_WIN_LO];
	wire [1:0] pos_win  = auto_q[acdpc_pkg::POS_WIN_HI:acdpc_pkg::POS_WIN_LO];
	wire       auto_en  = auto_q[acdpc_pkg::AUTO_BIT] && (mask != 3'h0);

	logic [2:0] div_cnt_q;
	logic       sysref_prev_q;

	wire       sysref_edge = sysref_s && !sysref_prev_q;
	// Counter value is the reference lateness; its wrap-around is earliness.
	wire [2:0] late_by     = div_cnt_q;
	wire [2:0] early_by    = (mask - div_cnt_q) + 3'h1;
	wire       in_pos_win  = (late_by != 3'h0) && (late_by <= {1'b0, pos_win});
	wire       in_neg_win  = (late_by != 3'h0) && (early_by <= {1'b0, neg_win});
	wire       realign     = auto_en && sysref_edge && (late_by != 3'h0) &&
	                         !in_pos_win && !in_neg_win;
	wire [2:0] div_cnt_d   = realign ? 3'h1 :
	                         (div_cnt_q >= mask) ? 3'h0 : div_cnt_q + 3'h1;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_cnt_q     <= 3'h0;
			sysref_prev_q <= 1'b0;
		end else begin
			div_cnt_q     <= div_cnt_d;
			sysref_prev_q <= sysref_s;
		end
	end

	logic [1:0] samp_en_d;
	logic [1:0] half_d;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			// Whole-cycle part selects the enable slot; odd values add a half cycle.
			samp_en_d[c] = (div_cnt_d == (phase_q[c][3:1] & mask));
			half_d[c]    = phase_q[c][0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_clk_en        <= 1'b0;
			sample_clk_en     <= 2'h0;
			sample_half_cycle <= 2'h0;
		end else begin
			div_clk_en        <= (div_cnt_d == 3'h0);
			sample_clk_en     <= samp_en_d;
			sample_half_cycle <= half_d;
		end
	end

	// ****************************************
	// Fine delay
	// ****************************************
	logic fine_en_prev_q;
	wire  fine_en = fine_en_q[acdpc_pkg::FINE_EN_BIT];

	function automatic logic [7:0] sat_skew(input logic [7:0] v);
		sat_skew = ($signed(v) < $signed(acdpc_pkg::FINE_SKEW_MIN)) ?
		           acdpc_pkg::FINE_SKEW_MIN : v;
	endfunction : sat_skew

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fine_en_prev_q    <= 1'b0;
			datapath_reset    <= 1'b0;
			fine_delay_active <= 1'b0;
			fine_skew         <= 16'h0000;
		end else begin
			fine_en_prev_q    <= fine_en;
			datapath_reset    <= fine_en && !fine_en_prev_q;
			fine_delay_active <= fine_en;
			fine_skew         <= fine_en ? {sat_skew(skew_q[1]), sat_skew(skew_q[0])}
			                             : 16'h0000;
		end
	end

	// ****************************************
	// Sleep pin and multipurpose pins
	// ****************************************
	wire [1:0] sleep_mode = pinsel_q[acdpc_pkg::SLEEP_MODE_HI:acdpc_pkg::SLEEP_MODE_LO];
	wire [2:0] fdb_sel    = pinsel_q[acdpc_pkg::FDB_HI:acdpc_pkg::FDB_LO];
	wire [2:0] fda_sel    = pinsel_q[acdpc_pkg::FDA_HI:acdpc_pkg::FDA_LO];

	logic [1:0] pd_d;
	logic [1:0] sb_d;
	logic [1:0] diode_d;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pd_d[c] = sleep_pin_s && !sleep_q[c][acdpc_pkg::SLEEP_IGN_BIT] &&
			          (sleep_mode == acdpc_pkg::SLEEP_POWER_DOWN);
			sb_d[c] = sleep_pin_s && !sleep_q[c][acdpc_pkg::SLEEP_IGN_BIT] &&
			          (sleep_mode == acdpc_pkg::SLEEP_STANDBY);
			diode_d[c] = diode_q[c][acdpc_pkg::DIODE_BIT] &&
			             (fda_sel == acdpc_pkg::FD_TEMP_DIODE);
		end
	end

	function automatic logic pin_value(input logic [2:0] sel, input logic flag);
		unique case (sel)
			acdpc_pkg::FD_FAST_FLAG: pin_value = flag;
			acdpc_pkg::FD_LMFC:      pin_value = lmfc_pulse;
			default:                 pin_value = sync_internal_n;
		endcase
	endfunction : pin_value

	wire fda_on = (fda_sel != acdpc_pkg::FD_DISABLE) &&
	              (fda_sel != acdpc_pkg::FD_TEMP_DIODE);
	wire fdb_on = (fdb_sel != acdpc_pkg::FD_DISABLE);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			chan_power_down  <= 2'h0;
			chan_standby     <= 2'h0;
			temp_diode_route <= 2'h0;
			fd_a_out         <= 1'b0;
			fd_a_oe          <= 1'b0;
			fd_b_out         <= 1'b0;
			fd_b_oe          <= 1'b0;
		end else begin
			chan_power_down  <= pd_d;
			chan_standby     <= sb_d;
			temp_diode_route <= diode_d;
			fd_a_out         <= fda_on && pin_value(fda_sel, fast_thresh_flag[0]);
			fd_a_oe          <= fda_on;
			fd_b_out         <= fdb_on && pin_value(fdb_sel, fast_thresh_flag[1]);
			fd_b_oe          <= fdb_on;
		end
	end

endmodule : acdpc_top
